//--- hdl/sfpm_top.sv
// Purpose: supply fault protection manager for a three-phase gate driver
// Assumes: fault flags are asynchronous levels from analog supervisors with hysteresis
// Notes: gate outputs are registered; enables are levels
// How it works
// - motor or logic undervoltage stops linear regulator, op amps, comparator; a running buck ignores motor undervoltage, logic undervoltage restarts its soft-start
// - motor, logic or gate supply undervoltage forces all high-side outputs low
// - same faults force all low-side outputs low; bootstrap fault leaves them
// - bootstrap undervoltage on a phase drops only that phase's high-side output
// - undervoltage set below off level, cleared only above the on level
// - overtemperature stops only the regulator where it was sensed
// - thermal stop clears by itself once temperature falls below threshold minus hysteresis
// - buck starts through a fixed-length soft-start
// - switch overcurrent latches buck off until motor supply is cycled
// - output undervoltage restarts buck with a new soft-start
// - with external supply and benign switch node, buck switch keeps toggling
// - switch node shorted to ground or logic supply latches buck off
// - both standby inputs low: after sleep delay, standby shutdown, buck keeps running
// - high and low side of one half-bridge never high together
// - undriven controller inputs read low so outputs stay off
`timescale 1ns/10ps
`default_nettype none
`include "sfpm_regs.svh"
module sfpm_top #(
  parameter int SLEEP_CYC = `SFPM_SLEEP_CYC,
  parameter int SOFTSTART_CYC = `SFPM_SOFTSTART_CYC,
  parameter int PHASES = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic high_gate_in_u,
  input wire logic high_gate_in_v,
  input wire logic high_gate_in_w,
  input wire logic low_gate_in_u,
  input wire logic low_gate_in_v,
  input wire logic low_gate_in_w,
  input wire logic threshold_standby_sel_a,
  input wire logic threshold_standby_sel_b,
  input wire logic motor_supply_uv,
  input wire logic logic_supply_uv,
  input wire logic gate_supply_uv,
  input wire logic [2:0] bootstrap_supply_uv,
  input wire logic linear_overtemp,
  input wire logic buck_overtemp,
  input wire logic switch_overcurrent,
  input wire logic switch_short,
  input wire logic regulator_output_uv,
  output logic high_gate_out_u,
  output logic high_gate_out_v,
  output logic high_gate_out_w,
  output logic low_gate_out_u,
  output logic low_gate_out_v,
  output logic low_gate_out_w,
  output logic linear_reg_enable,
  output logic amp_comp_enable,
  output logic buck_enable,
  output logic buck_soft_start,
  output logic standby_active
);
  import sfpm_pkg::*;
  localparam int NF = 11;
  localparam int SW = $clog2(SLEEP_CYC + 1);

  // inputs from the controller are levels from another domain too
  logic [5:0] gate_raw;
  logic [5:0] gate_sync;
  logic [1:0] stby_sync;
  logic [NF-1:0] flt_raw;
  logic [NF-1:0] flt;
  logic vm_uv;
  logic vdd_uv;
  logic vreg_uv;
  logic [2:0] boot_uv;
  logic lin_ot;
  logic buck_ot;
  logic sw_oc;
  logic sw_short;
  logic out_uv;
  logic stby_req;
  logic [SW-1:0] sleep_cnt;
  logic [SW-1:0] stby_held;
  logic common_uv;
  logic [2:0] hi_in;
  logic [2:0] lo_in;
  logic [2:0] next_hi;
  logic [2:0] next_lo;
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  sfpm_buck_t buck_state;

  assign gate_raw = {low_gate_in_w, low_gate_in_v, low_gate_in_u,
                     high_gate_in_w, high_gate_in_v, high_gate_in_u};
  assign flt_raw = {regulator_output_uv, switch_short, switch_overcurrent, buck_overtemp,
                    linear_overtemp, bootstrap_supply_uv, gate_supply_uv,
                    logic_supply_uv, motor_supply_uv};

  // gate and standby inputs reset low, as an undriven pin reads
  sfpm_sync #(.WIDTH(6), .INIT(6'h00)) u_gate_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(gate_raw),
    .sync_out(gate_sync)
  );

  sfpm_sync #(.WIDTH(2), .INIT(2'h0)) u_stby_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({threshold_standby_sel_b, threshold_standby_sel_a}),
    .sync_out(stby_sync)
  );

  // supply undervoltage flags reset asserted, the other fault flags reset clear: no supply is trusted until the supervisors are seen
  sfpm_sync #(.WIDTH(NF), .INIT(11'h03f)) u_flt_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(flt_raw),
    .sync_out(flt)
  );

  // hysteresis lives in the supervisors; the flag is only released above the on level
  assign vm_uv = flt[0];
  assign vdd_uv = flt[1];
  assign vreg_uv = flt[2];
  assign boot_uv = flt[5:3];
  assign lin_ot = flt[6];
  assign buck_ot = flt[7];
  assign sw_oc = flt[8];
  assign sw_short = flt[9];
  assign out_uv = flt[10] || vdd_uv; // own output monitor, or the logic monitor it feeds
  assign hi_in = gate_sync[2:0];
  assign lo_in = gate_sync[5:3];
  assign stby_req = !stby_sync[0] && !stby_sync[1];

  // sleep delay before the analog side drops into low consumption
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sleep_cnt <= '0;
      standby_active <= 1'b0;
    end else if (!stby_req) begin
      sleep_cnt <= '0;
      standby_active <= 1'b0;
    end else if (sleep_cnt == SW'(SLEEP_CYC - 1)) begin
      standby_active <= 1'b1;
    end else begin
      sleep_cnt <= sleep_cnt + SW'(1);
    end
  end

  assign common_uv = vm_uv || vdd_uv || vreg_uv;

  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      // a phase asking for both sides gets neither
      next_hi[p] = hi_in[p] && !lo_in[p] && !standby_active
                   && !common_uv && !boot_uv[p];
      next_lo[p] = lo_in[p] && !hi_in[p] && !standby_active
                   && !common_uv;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
    end else begin
      hi_q <= next_hi;
      lo_q <= next_lo;
    end
  end

  assign high_gate_out_u = hi_q[0];
  assign high_gate_out_v = hi_q[1];
  assign high_gate_out_w = hi_q[2];
  assign low_gate_out_u = lo_q[0];
  assign low_gate_out_v = lo_q[1];
  assign low_gate_out_w = lo_q[2];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      linear_reg_enable <= 1'b0;
      amp_comp_enable <= 1'b0;
    end else begin
      // thermal flag drops by itself once cooled, so the enable comes back
      linear_reg_enable <= !vm_uv && !vdd_uv && !lin_ot && !standby_active;
      amp_comp_enable <= !vm_uv && !vdd_uv && !standby_active;
    end
  end

  // buck sees motor undervoltage only at start and latch clear, logic undervoltage as an output fault, and runs through standby
  sfpm_buck_ctrl #(.SOFTSTART_CYC(SOFTSTART_CYC)) u_buck (
    .clk(clk),
    .resetn(resetn),
    .motor_present(!vm_uv),
    .switch_overcurrent(sw_oc),
    .switch_short(sw_short),
    .output_undervoltage(out_uv),
    .buck_overtemp(buck_ot),
    .buck_state(buck_state),
    .buck_enable(buck_enable),
    .buck_soft_start(buck_soft_start)
  );

  // cycles the standby request has been seen, saturating; only the checks below read it
  always_ff @(posedge clk) begin
    if (!resetn || !stby_req) begin
      stby_held <= '0;
    end else if (stby_held != SW'(SLEEP_CYC)) begin
      stby_held <= stby_held + SW'(1);
    end
  end

  sequence s_sleep_done;
    stby_req && stby_held == SW'(SLEEP_CYC);
  endsequence

  property p_interlock;
    @(posedge clk) disable iff (!resetn)
      !((high_gate_out_u && low_gate_out_u) || (high_gate_out_v && low_gate_out_v)
        || (high_gate_out_w && low_gate_out_w));
  endproperty
  a_interlock: assert property (p_interlock) else $error("half-bridge shoot-through");

  property p_uv_all_low;
    @(posedge clk) disable iff (!resetn)
      common_uv |=> (hi_q == 3'h0 && lo_q == 3'h0);
  endproperty
  a_uv_all_low: assert property (p_uv_all_low) else $error("gate high during supply fault");

  property p_boot_lo_kept;
    @(posedge clk) disable iff (!resetn)
      (boot_uv[0] && !common_uv && !standby_active && lo_in[0] && !hi_in[0])
      |=> low_gate_out_u && !high_gate_out_u;
  endproperty
  a_boot_lo_kept: assert property (p_boot_lo_kept) else $error("bootstrap fault hit low");

  property p_boot_phase;
    @(posedge clk) disable iff (!resetn)
      (boot_uv == 3'h1 && !common_uv && !standby_active && hi_in[1] && !lo_in[1])
      |=> high_gate_out_v && !high_gate_out_u;
  endproperty
  a_boot_phase: assert property (p_boot_phase) else $error("bootstrap fault not per phase");

  property p_gate_cause;
    @(posedge clk) disable iff (!resetn)
      $rose(high_gate_out_w) |-> $past(hi_in[2]) && !$past(standby_active);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate rose without request");

  property p_standby;
    @(posedge clk) disable iff (!resetn)
      s_sleep_done |-> standby_active;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered after sleep");

  property p_stby_early;
    @(posedge clk) disable iff (!resetn)
      (stby_held != SW'(SLEEP_CYC)) |-> !standby_active;
  endproperty
  a_stby_early: assert property (p_stby_early) else $error("standby entered early");

  property p_stby_off;
    @(posedge clk) disable iff (!resetn)
      standby_active |=> !linear_reg_enable && !amp_comp_enable && hi_q == 3'h0;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby left blocks on");

  property p_lin_ot;
    @(posedge clk) disable iff (!resetn)
      lin_ot |=> !linear_reg_enable;
  endproperty
  a_lin_ot: assert property (p_lin_ot) else $error("linear regulator on while hot");

  property p_lin_recover;
    @(posedge clk) disable iff (!resetn)
      (!lin_ot && !vm_uv && !vdd_uv && !standby_active) |=> linear_reg_enable;
  endproperty
  a_lin_recover: assert property (p_lin_recover) else $error("linear regulator stayed off");

  property p_vm_amp;
    @(posedge clk) disable iff (!resetn)
      vm_uv |=> !amp_comp_enable && !linear_reg_enable;
  endproperty
  a_vm_amp: assert property (p_vm_amp) else $error("amps on in undervoltage");

  property p_stby_buck;
    @(posedge clk) disable iff (!resetn)
      (standby_active && buck_state == SFPM_BUCK_RUN && !sw_oc && !sw_short && !buck_ot)
      |=> buck_enable;
  endproperty
  a_stby_buck: assert property (p_stby_buck) else $error("buck stopped by standby");

  property p_boot_hi_off;
    @(posedge clk) disable iff (!resetn)
      boot_uv[2] |=> !high_gate_out_w;
  endproperty
  a_boot_hi_off: assert property (p_boot_hi_off) else $error("high side on in boot fault");

  property p_lo_cause;
    @(posedge clk) disable iff (!resetn)
      $rose(low_gate_out_u) |-> $past(lo_in[0]) && !$past(common_uv) && !$past(standby_active);
  endproperty
  a_lo_cause: assert property (p_lo_cause) else $error("low side rose without request");
endmodule
`default_nettype wire

//--- hdl/sfpm_regs.svh
// Purpose: timing counts and synchroniser depth for the supply fault protection manager
// Assumes: 250 MHz logic clock
// Notes: times in ns, counts derived by the block
`ifndef SFPM_REGS_SVH
`define SFPM_REGS_SVH
`define SFPM_CLK_PERIOD_NS 4
`define SFPM_SLEEP_NS 20000
`define SFPM_SOFTSTART_NS 40000
`define SFPM_SLEEP_CYC ((`SFPM_SLEEP_NS + `SFPM_CLK_PERIOD_NS - 1) / `SFPM_CLK_PERIOD_NS)
`define SFPM_SOFTSTART_CYC ((`SFPM_SOFTSTART_NS + `SFPM_CLK_PERIOD_NS - 1) / `SFPM_CLK_PERIOD_NS)
`define SFPM_SYNC_STAGES 3
`endif

//--- hdl/sfpm_pkg.sv
// Purpose: shared types of the supply fault protection manager
// Assumes: nothing
// Notes: buck states
package sfpm_pkg;
  typedef enum logic [1:0] {
    SFPM_BUCK_OFF = 2'b00,
    SFPM_BUCK_SOFT = 2'b01,
    SFPM_BUCK_RUN = 2'b10,
    SFPM_BUCK_LATCHED = 2'b11
  } sfpm_buck_t;
endpackage

//--- hdl/sfpm_sync.sv
// Purpose: three-stage synchroniser with second/third agreement filter
// Assumes: asynchronous input bits
// Notes: first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module sfpm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!resetn) begin
        s1[i] <= INIT[i];
        s2[i] <= INIT[i];
        s3[i] <= INIT[i];
        sync_out[i] <= INIT[i];
      end else begin
        s1[i] <= async_in[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        // a change counts once two later stages agree
        if (s2[i] == s3[i]) begin
          sync_out[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/sfpm_buck_ctrl.sv
// Purpose: buck regulator start, soft-start retry and latch-off control
// Assumes: fault inputs already synchronised
// Notes: latch clears only on a motor supply power cycle
`timescale 1ns/10ps
`default_nettype none
`include "sfpm_regs.svh"
module sfpm_buck_ctrl #(
  parameter int SOFTSTART_CYC = `SFPM_SOFTSTART_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic motor_present,
  input wire logic switch_overcurrent,
  input wire logic switch_short,
  input wire logic output_undervoltage,
  input wire logic buck_overtemp,
  output sfpm_pkg::sfpm_buck_t buck_state,
  output logic buck_enable,
  output logic buck_soft_start
);
  import sfpm_pkg::*;
  localparam int CW = $clog2(SOFTSTART_CYC + 1);
  logic [CW-1:0] soft_cnt;
  sfpm_buck_t next_state;

  always_comb begin
    next_state = buck_state;
    case (buck_state)
      SFPM_BUCK_OFF: begin
        if (motor_present && !buck_overtemp) begin
          next_state = SFPM_BUCK_SOFT;
        end
      end
      SFPM_BUCK_SOFT, SFPM_BUCK_RUN: begin
        if (switch_overcurrent || switch_short) begin
          next_state = SFPM_BUCK_LATCHED;
        end else if (buck_overtemp) begin
          next_state = SFPM_BUCK_OFF;
        end else if (output_undervoltage && buck_state == SFPM_BUCK_RUN) begin
          next_state = SFPM_BUCK_SOFT;
        end else if (buck_state == SFPM_BUCK_SOFT &&
                     soft_cnt == CW'(SOFTSTART_CYC - 1)) begin
          next_state = SFPM_BUCK_RUN;
        end
      end
      SFPM_BUCK_LATCHED: begin
        if (!motor_present) begin
          next_state = SFPM_BUCK_OFF;
        end
      end
      default: next_state = SFPM_BUCK_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      buck_state <= SFPM_BUCK_OFF;
    end else begin
      buck_state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      soft_cnt <= '0;
    end else if (buck_state != SFPM_BUCK_SOFT || next_state != SFPM_BUCK_SOFT) begin
      soft_cnt <= '0;
    end else begin
      soft_cnt <= soft_cnt + CW'(1);
    end
  end

  // the switch toggles in soft-start and run; latch, thermal stop or no motor supply at start holds it off
  assign buck_enable = (buck_state == SFPM_BUCK_SOFT) || (buck_state == SFPM_BUCK_RUN);
  assign buck_soft_start = (buck_state == SFPM_BUCK_SOFT);

  property p_latch_on_oc;
    @(posedge clk) disable iff (!resetn)
      (buck_enable && switch_overcurrent) |=> buck_state == SFPM_BUCK_LATCHED;
  endproperty
  a_latch_on_oc: assert property (p_latch_on_oc) else $error("buck not latched");

  property p_latch_holds;
    @(posedge clk) disable iff (!resetn)
      (buck_state == SFPM_BUCK_LATCHED && motor_present) |=> buck_state == SFPM_BUCK_LATCHED;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("buck latch left early");

  property p_short_latch;
    @(posedge clk) disable iff (!resetn)
      (buck_enable && switch_short) |=> !buck_enable;
  endproperty
  a_short_latch: assert property (p_short_latch) else $error("buck not stopped on short");

  property p_retry;
    @(posedge clk) disable iff (!resetn)
      (buck_state == SFPM_BUCK_RUN && output_undervoltage && !switch_overcurrent
       && !switch_short && !buck_overtemp) |=> buck_soft_start;
  endproperty
  a_retry: assert property (p_retry) else $error("no soft-start retry on output fault");
endmodule
`default_nettype wire

//--- sim/sfpm_mcu_model.sv
// Purpose: controller model driving the gate request and standby select lines
// Assumes: lines change on the falling clock edge
// Notes: the threshold select code outside standby is arbitrary
`timescale 1ns/10ps
`default_nettype none
module sfpm_mcu_model (
  input wire logic clk,
  input wire logic [5:0] cmd_gate,
  input wire logic cmd_standby,
  output logic [5:0] gate_line,
  output logic sel_a,
  output logic sel_b
);
  // lines start low, as undriven pins with pull-downs would read; one process drives them
  // gate requests stay as commanded in standby, so the block must do the gating itself
  initial begin
    gate_line = 6'h00;
    sel_a = 1'b0;
    sel_b = 1'b0;
    forever begin
      @(negedge clk);
      gate_line <= cmd_gate;
      sel_a <= !cmd_standby;
      sel_b <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Purpose: self-checking bench for the supply fault protection manager
// Assumes: short sleep and soft-start counts
// Notes: obs packs {standby, soft, buck, amp, lin, low w v u, high w v u}
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int SLP = 8;
  localparam int SFT = 8;
  localparam logic [10:0] ON = 11'h1c0;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] cmd = 6'h00;
  logic stby = 1'b0;
  logic muv = 1'b0;
  logic luv = 1'b0;
  logic guv = 1'b0;
  logic [2:0] buv = 3'h0;
  logic lot = 1'b0;
  logic bot = 1'b0;
  logic soc = 1'b0;
  logic ssh = 1'b0;
  logic ouv = 1'b0;
  int n_fail = 0;
  int n_tests = 0;
  int c;
  wire logic [5:0] gl;
  wire logic sa;
  wire logic sb;
  wire logic [10:0] obs;
  always #2 clk = ~clk;
  sfpm_mcu_model sfpm_mcu_model_i (.clk(clk), .cmd_gate(cmd), .cmd_standby(stby),
    .gate_line(gl), .sel_a(sa), .sel_b(sb));
  sfpm_top #(.SLEEP_CYC(SLP), .SOFTSTART_CYC(SFT)) sfpm_top_i (.clk(clk), .resetn(resetn),
    .high_gate_in_u(gl[0]), .high_gate_in_v(gl[1]), .high_gate_in_w(gl[2]),
    .low_gate_in_u(gl[3]), .low_gate_in_v(gl[4]), .low_gate_in_w(gl[5]),
    .threshold_standby_sel_a(sa), .threshold_standby_sel_b(sb),
    .motor_supply_uv(muv), .logic_supply_uv(luv), .gate_supply_uv(guv),
    .bootstrap_supply_uv(buv), .linear_overtemp(lot), .buck_overtemp(bot),
    .switch_overcurrent(soc), .switch_short(ssh), .regulator_output_uv(ouv),
    .high_gate_out_u(obs[0]), .high_gate_out_v(obs[1]), .high_gate_out_w(obs[2]),
    .low_gate_out_u(obs[3]), .low_gate_out_v(obs[4]), .low_gate_out_w(obs[5]),
    .linear_reg_enable(obs[6]), .amp_comp_enable(obs[7]), .buck_enable(obs[8]),
    .buck_soft_start(obs[9]), .standby_active(obs[10]));

  task automatic complete_run();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [10:0] seen, input logic [10:0] exp, input logic [10:0] m);
    n_tests++;
    if ((seen & m) !== (exp & m)) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait on one observed bit; n returns the cycles spent
  task automatic wait_obs(input int idx, input logic v, input int lim, output int n);
    n = 0;
    while (obs[idx] !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        n_fail++;
        $display("ERROR t=%0t no change on output bit %0d", $time, idx);
        complete_run();
      end
    end
  endtask
  task automatic soft_cycle();
    wait_obs(9, 1'b1, 30, c);
    check(obs, 11'h300, 11'h300);
    wait_obs(9, 1'b0, SFT + 30, c);
    check({10'h000, c >= SFT - 1 && c <= SFT + 1}, 11'h001, 11'h7ff);
    cyc(2);
    check(obs, ON, 11'h7ff);
  endtask
  task automatic t_gates();
    for (int i = 0; i < 6; i++) begin
      cmd = 6'h01 << i;
      cyc(2);
      check(obs, ON | ((11'h001 << i) >> 1), 11'h7ff);
      cyc(8);
      check(obs, ON | (11'h001 << i), 11'h7ff);
    end
    for (int p = 0; p < 3; p++) begin
      cmd = (6'h01 << p) | (6'h08 << p);
      cyc(10);
      check(obs, ON, 11'h7ff);
    end
    cmd = 6'h00;
    $display("test gates done");
  endtask
  task automatic t_common_uv();
    for (int f = 0; f < 3; f++) begin
      {guv, luv, muv} = 3'h1 << f;
      cmd = 6'h07;
      cyc(10);
      check(obs, (f == 2) ? ON : 11'h100, (f == 1) ? 11'h4ff : 11'h7ff);
      cmd = 6'h38;
      cyc(10);
      check(obs, 11'h000, 11'h03f);
      {guv, luv, muv} = 3'h0;
      cmd = 6'h00;
      cyc(30);
      check(obs, ON, 11'h7ff);
    end
    $display("test common undervoltage done");
  endtask
  task automatic t_boot_uv();
    for (int p = 0; p < 3; p++) begin
      buv = 3'h1 << p;
      cmd = 6'h07;
      cyc(10);
      check(obs, ON | (11'h007 & ~(11'h001 << p)), 11'h7ff);
      cmd = 6'h38;
      cyc(10);
      check(obs, ON | 11'h038, 11'h7ff);
    end
    buv = 3'h0;
    cmd = 6'h00;
    cyc(10);
    $display("test bootstrap undervoltage done");
  endtask
  task automatic t_thermal();
    lot = 1'b1;
    cyc(10);
    check(obs, 11'h180, 11'h7ff);
    lot = 1'b0;
    cyc(10);
    check(obs, ON, 11'h7ff);
    bot = 1'b1;
    cyc(10);
    check(obs, 11'h0c0, 11'h7ff);
    bot = 1'b0;
    soft_cycle();
    $display("test thermal done");
  endtask
  task automatic t_standby();
    cmd = 6'h01;
    cyc(10);
    stby = 1'b1;
    cyc(4);
    check(obs, ON | 11'h001, 11'h7ff);
    wait_obs(10, 1'b1, SLP + 20, c);
    cyc(2);
    check(obs, 11'h500, 11'h7ff);
    stby = 1'b0;
    cyc(10);
    check(obs, ON | 11'h001, 11'h7ff);
    cmd = 6'h00;
    $display("test standby done");
  endtask
  task automatic t_latch(input int k);
    soc = (k == 0);
    ssh = (k == 1);
    cyc(10);
    soc = 1'b0;
    ssh = 1'b0;
    cyc(20);
    check(obs, 11'h0c0, 11'h7ff);
    muv = 1'b1;
    cyc(10);
    muv = 1'b0;
    soft_cycle();
    $display("test buck latch %0d done", k);
  endtask
  task automatic t_retry();
    for (int k = 0; k < 2; k++) begin
      luv = (k == 0);
      ouv = (k == 1);
      cyc(3);
      luv = 1'b0;
      ouv = 1'b0;
      soft_cycle();
    end
    $display("test buck retry done");
  endtask

  initial begin
    cyc(16);
    check(obs, 11'h000, 11'h7ff);
    resetn = 1'b1;
    wait_obs(8, 1'b1, 30, c);
    wait_obs(9, 1'b0, SFT + 30, c);
    cyc(2);
    check(obs, ON, 11'h7ff);
    t_gates();
    t_common_uv();
    t_boot_uv();
    t_thermal();
    t_standby();
    t_latch(0);
    t_latch(1);
    t_retry();
    complete_run();
  end
endmodule
`default_nettype wire
